// ### design/mbse_responder.sv
// request checker, scale converter and exception frame builder
// assumes the frame receiver fills the request struct and checks crc,
// and that the parameter table supplies address, range and attribute flags
//
// Operation
// - bus value equals parameter value times ten to its decimal count
// - writes divide by scale before storing; reads multiply stored value by scale
// - unimplemented function code or faulty slave answers error 01H
// - bad address and quantity combination answers error 02H
// - structurally disallowed data field answers error 03H
// - invalid written value answers error 04H
// - wrong password at verification address answers error 05H
// - wrong frame length or crc mismatch answers error 06H
// - write to read-only parameter answers 07H, value left unchanged
// - run-locked parameter written while running answers error 08H
// - locked device rejects any read or write except the password write with error 09H
// - normal response echoes function code and address or sub-function
// - exception response sets top bit of received function code
// - exception carries exactly one error byte after function code
`timescale 1ns/1ps
module mbse_responder
#(
  parameter logic [7:0] STATION_ADDR = 8'h01
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic reqValid,
  input wire mbse_pkg::mbse_req_t req,
  input wire logic slaveFaulty,
  input wire logic driveRunning,
  input wire logic [15:0] userPasswordSetting,
  input wire logic [15:0] storedValue,
  output logic respValid,
  output mbse_pkg::mbse_resp_t resp,
  output logic [15:0] respCrc,
  output logic storeValid,
  output logic [15:0] storeAddr,
  output logic [15:0] storeData,
  output logic unlocked
);
  logic respValid_r, respValid_nxt;
  mbse_pkg::mbse_resp_t resp_r, resp_nxt;
  logic [15:0] respCrc_r, respCrc_nxt;
  logic storeValid_r, storeValid_nxt;
  logic [15:0] storeAddr_r, storeAddr_nxt;
  logic [15:0] storeData_r, storeData_nxt;
  logic unlocked_r, unlocked_nxt;
  logic [7:0] errCode;
  logic [15:0] scale;
  logic [15:0] crcA, crcB, crcC;
  logic isWrite, fcKnown, locked;

  // scale is ten raised to the parameter's decimal count
  always_comb
  begin
    case (req.decimals)
      2'h0: scale = 16'h0001;
      2'h1: scale = 16'h000a;
      2'h2: scale = 16'h0064;
      2'h3: scale = 16'h03e8; // MAX_DECIMALS caps the table
      default: scale = 16'h0001;
    endcase
  end

  assign isWrite = (req.funcCode == mbse_pkg::FC_WRITE) ||
    (req.funcCode == mbse_pkg::FC_WRITE_MULTI);
  assign fcKnown = isWrite || (req.funcCode == mbse_pkg::FC_READ) ||
    (req.funcCode == mbse_pkg::FC_DIAG);
  // a zero password means none is set
  assign locked = (userPasswordSetting != mbse_pkg::WORD_RESET) && !unlocked_r;

  // priority chain yields exactly one code per request
  always_comb
  begin
    if (!req.frameLenOk || !req.crcOk)
      errCode = mbse_pkg::ERR_FRAME;
    else if (!fcKnown || slaveFaulty)
      errCode = mbse_pkg::ERR_BAD_CMD;
    else if (req.pwdWrite && isWrite)
      errCode = (req.data == userPasswordSetting) ? mbse_pkg::ERR_NONE :
        mbse_pkg::ERR_PASSWORD;
    else if (locked)
      errCode = mbse_pkg::ERR_LOCKED;
    else if (!req.addrOk)
      errCode = mbse_pkg::ERR_BAD_ADDR;
    else if (!req.dataFieldOk)
      errCode = mbse_pkg::ERR_BAD_DATA;
    else if (isWrite && req.readOnly)
      errCode = mbse_pkg::ERR_READ_ONLY;
    else if (isWrite && req.noRunChange && driveRunning)
      errCode = mbse_pkg::ERR_RUNNING;
    else if (isWrite && !req.valueOk)
      errCode = mbse_pkg::ERR_OP_FAIL;
    else
      errCode = mbse_pkg::ERR_NONE;
  end

  // crc over station, function and error byte of an exception frame
  mbse_crc16 u_crc_a
  (
    .crcIn(mbse_pkg::CRC_INIT),
    .dataByte(STATION_ADDR),
    .crcOut(crcA)
  );
  mbse_crc16 u_crc_b
  (
    .crcIn(crcA),
    .dataByte(req.funcCode | mbse_pkg::EXC_FLAG),
    .crcOut(crcB)
  );
  mbse_crc16 u_crc_c
  (
    .crcIn(crcB),
    .dataByte(errCode),
    .crcOut(crcC)
  );

  // next-state for response, store and unlock state
  always_comb
  begin
    respValid_nxt = 1'b0;
    resp_nxt = resp_r;
    respCrc_nxt = respCrc_r;
    storeValid_nxt = 1'b0;
    storeAddr_nxt = storeAddr_r;
    storeData_nxt = storeData_r;
    unlocked_nxt = unlocked_r;
    // dropping the password clears the unlock so a later one relocks
    if (userPasswordSetting == mbse_pkg::WORD_RESET)
      unlocked_nxt = 1'b0;
    if (reqValid)
    begin
      respValid_nxt = 1'b1;
      resp_nxt.station = STATION_ADDR;
      resp_nxt.regAddr = req.regAddr;
      resp_nxt.errCode = errCode;
      resp_nxt.isException = (errCode != mbse_pkg::ERR_NONE);
      if (errCode != mbse_pkg::ERR_NONE)
      begin
        resp_nxt.funcCode = req.funcCode | mbse_pkg::EXC_FLAG;
        resp_nxt.data = mbse_pkg::WORD_RESET;
        respCrc_nxt = crcC;
      end
      else
      begin
        resp_nxt.funcCode = req.funcCode;
        respCrc_nxt = mbse_pkg::CRC_INIT; // normal frames get crc downstream
        if (isWrite)
          resp_nxt.data = req.data; // write echoes the request
        else
          resp_nxt.data = 16'(storedValue * scale);
        if (req.pwdWrite && isWrite)
          unlocked_nxt = 1'b1;
        else if (isWrite)
        begin
          // read-only and failed writes never reach here, value unchanged
          storeValid_nxt = 1'b1;
          storeAddr_nxt = req.regAddr;
          storeData_nxt = req.data / scale;
        end
      end
    end
  end

  // registers only
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      respValid_r <= 1'b0;
      resp_r <= '0;
      respCrc_r <= mbse_pkg::CRC_INIT;
      storeValid_r <= 1'b0;
      storeAddr_r <= mbse_pkg::WORD_RESET;
      storeData_r <= mbse_pkg::WORD_RESET;
      unlocked_r <= 1'b0;
    end
    else
    begin
      respValid_r <= respValid_nxt;
      resp_r <= resp_nxt;
      respCrc_r <= respCrc_nxt;
      storeValid_r <= storeValid_nxt;
      storeAddr_r <= storeAddr_nxt;
      storeData_r <= storeData_nxt;
      unlocked_r <= unlocked_nxt;
    end
  end

  assign respValid = respValid_r;
  assign resp = resp_r;
  assign respCrc = respCrc_r;
  assign storeValid = storeValid_r;
  assign storeAddr = storeAddr_r;
  assign storeData = storeData_r;
  assign unlocked = unlocked_r;
endmodule

// ### design/mbse_pkg.sv
// package for the request checker and exception responder
// assumes a single 250 MHz clock domain shared by all users
package mbse_pkg;
  // error codes carried in exception frames
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_BAD_CMD = 8'h01;
  localparam logic [7:0] ERR_BAD_ADDR = 8'h02;
  localparam logic [7:0] ERR_BAD_DATA = 8'h03;
  localparam logic [7:0] ERR_OP_FAIL = 8'h04;
  localparam logic [7:0] ERR_PASSWORD = 8'h05;
  localparam logic [7:0] ERR_FRAME = 8'h06;
  localparam logic [7:0] ERR_READ_ONLY = 8'h07;
  localparam logic [7:0] ERR_RUNNING = 8'h08;
  localparam logic [7:0] ERR_LOCKED = 8'h09;
  // function codes handled here
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE = 8'h06;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [3:0] SCALE_BASE = 4'ha;
  localparam logic [1:0] MAX_DECIMALS = 2'h3;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // one decoded request with the parameter attributes looked up for it
  typedef struct packed {
    logic [7:0] funcCode;
    logic [15:0] regAddr;
    logic [15:0] quantity;
    logic [15:0] data;
    logic frameLenOk;
    logic crcOk;
    logic addrOk;
    logic dataFieldOk;
    logic valueOk;
    logic pwdWrite;
    logic readOnly;
    logic noRunChange;
    logic [1:0] decimals;
  } mbse_req_t;

  // outgoing frame header, before the crc is appended
  typedef struct packed {
    logic [7:0] station;
    logic [7:0] funcCode;
    logic [7:0] errCode;
    logic [15:0] regAddr;
    logic [15:0] data;
    logic isException;
  } mbse_resp_t;
endpackage

// ### design/mbse_crc16.sv
// byte-serial crc-16 for outgoing frames, one byte per call
// assumes caller holds the running value and seeds it with the init value
`timescale 1ns/1ps
module mbse_crc16
(
  input wire logic [15:0] crcIn,
  input wire logic [7:0] dataByte,
  output logic [15:0] crcOut
);
  // eight shift steps unrolled by the loop, reflected polynomial
  always_comb
  begin
    logic [15:0] c;
    c = crcIn ^ {8'h00, dataByte};
    for (int i = 0; i < 8; i++)
    begin
      if (c[0])
        c = (c >> 1) ^ mbse_pkg::CRC_POLY;
      else
        c = c >> 1;
    end
    crcOut = c;
  end
endmodule

// ### tb/mbse_responder_asserts.sv
// port assertions for the request checker and exception responder
// bound to every responder instance; single clock domain
`timescale 1ns/1ps
module mbse_responder_asserts
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic reqValid,
  input wire mbse_pkg::mbse_req_t req,
  input wire logic slaveFaulty,
  input wire logic respValid,
  input wire mbse_pkg::mbse_resp_t resp,
  input wire logic storeValid
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // a taken request and the kind of its answer
  sequence s_exc;
    reqValid ##1 resp.isException;
  endsequence
  sequence s_norm;
    reqValid ##1 !resp.isException;
  endsequence
  property p_answer; reqValid |=> respValid; endproperty
  a_answer: assert property (p_answer) else $error("request without answer");
  property p_quiet; !reqValid |=> !respValid && !storeValid; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");
  property p_frame; reqValid && !req.crcOk |=> resp.errCode == 8'h06; endproperty
  a_frame: assert property (p_frame) else $error("crc fault not code 06");
  property p_fault; reqValid && req.frameLenOk && req.crcOk && slaveFaulty |=>
    resp.errCode == 8'h01;
  endproperty
  a_fault: assert property (p_fault) else $error("faulty slave not code 01");
  property p_excfc; s_exc |-> resp.funcCode == ($past(req.funcCode) | 8'h80); endproperty
  a_excfc: assert property (p_excfc) else $error("exception function code wrong");
  property p_normfc; s_norm |-> resp.regAddr == $past(req.regAddr) &&
    resp.funcCode == $past(req.funcCode);
  endproperty
  a_normfc: assert property (p_normfc) else $error("normal echo wrong");
  property p_onecode; respValid |-> resp.isException == (resp.errCode != 8'h00); endproperty
  a_onecode: assert property (p_onecode) else $error("error byte mismatch");
  property p_ro; reqValid && req.readOnly && req.funcCode == 8'h06 |=> !storeValid; endproperty
  a_ro: assert property (p_ro) else $error("read-only parameter stored");
endmodule
bind mbse_responder mbse_responder_asserts chk_inst (.clock(clock), .sys_rst(sys_rst),
  .reqValid(reqValid), .req(req), .slaveFaulty(slaveFaulty), .respValid(respValid),
  .resp(resp), .storeValid(storeValid));

// ### tb/mbse_master_model.sv
// master model issuing one decoded request at a time
// assumes the responder samples requests on the rising edge
`timescale 1ns/1ps
module mbse_master_model
(
  input wire logic clock,
  output logic reqValid,
  output mbse_pkg::mbse_req_t req
);
  initial reqValid = 1'b0;
  initial req = '0;
  // pulse for one edge, then show the inverse so stale data cannot match
  task automatic send(input mbse_pkg::mbse_req_t r);
    @(posedge clock);
    reqValid <= 1'b1;
    req <= r;
    @(posedge clock);
    reqValid <= 1'b0;
    req <= ~r;
  endtask
endmodule

// ### tb/mbse_responder_tb.sv
// self-checking bench for the responder, master model in front
// one clock domain; answers are looked at in their single cycle
`timescale 1ns/1ps
module mbse_responder_tb;
  logic clock, sys_rst, reqValid, respValid, storeValid, unlocked, slaveFaulty, driveRunning;
  logic [15:0] userPasswordSetting, storedValue, respCrc, storeAddr, storeData;
  mbse_pkg::mbse_req_t req;
  mbse_pkg::mbse_resp_t resp;
  int num_errors = 0;
  int comparisons = 0;
  mbse_master_model mbse_master_model_inst (.clock(clock), .reqValid(reqValid), .req(req));
  mbse_responder mbse_responder_inst (.clock(clock), .sys_rst(sys_rst), .reqValid(reqValid),
    .req(req), .slaveFaulty(slaveFaulty), .driveRunning(driveRunning), .unlocked(unlocked),
    .userPasswordSetting(userPasswordSetting), .storedValue(storedValue), .resp(resp),
    .respValid(respValid), .respCrc(respCrc), .storeValid(storeValid),
    .storeAddr(storeAddr), .storeData(storeData));
  // 4 ns clock
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
      $display("[ERR] %s expected %h seen %h", n, e, g);
    num_errors += int'(g !== e);
  endtask
  // flags: length, crc, addr, data, value, pwd, read-only, no-run, decimals
  function automatic mbse_pkg::mbse_req_t rq(logic [7:0] fc, logic [9:0] fl, logic [15:0] d);
    return {fc, 16'h0114, 16'h0001, d, fl};
  endfunction
  // level inputs move on a rising edge only
  task automatic lvl(input logic [33:0] v);
    @(posedge clock);
    {slaveFaulty, driveRunning, userPasswordSetting, storedValue} <= v;
  endtask
  task automatic xfer(input mbse_pkg::mbse_req_t r, input logic [7:0] code);
    mbse_master_model_inst.send(r);
    #1;
    chk("respValid", 16'h0001, {15'h0, respValid});
    chk("errCode", {8'h0, code}, {8'h0, resp.errCode});
    chk("funcCode", {8'h0, code != 8'h0, r.funcCode[6:0]}, {8'h0, resp.funcCode});
    chk("isException", {15'h0, code != 8'h0}, {15'h0, resp.isException});
    chk("station", 16'h0001, {8'h0, resp.station});
    // normal frames echo the address and leave the crc to the framer
    if (code == 8'h0)
    begin
      chk("regAddr", 16'h0114, resp.regAddr);
      chk("normCrc", 16'hffff, respCrc);
    end
  endtask
  // every fault except password, lock and unknown function code present, then cleared one at a time, highest first
  task automatic t_prio;
    lvl({2'h3, 32'h0});
    xfer(rq(8'h06, 10'h00e, 16'h1394), 8'h06);
    xfer(rq(8'h06, 10'h20e, 16'h1394), 8'h06);
    xfer(rq(8'h06, 10'h30e, 16'h1394), 8'h01);
    lvl({2'h1, 32'h0});
    xfer(rq(8'h06, 10'h30e, 16'h1394), 8'h02);
    xfer(rq(8'h06, 10'h38e, 16'h1394), 8'h03);
    xfer(rq(8'h06, 10'h3ce, 16'h1394), 8'h07);
    chk("storeValid", 16'h0000, {15'h0, storeValid});
    xfer(rq(8'h06, 10'h3c6, 16'h1394), 8'h08);
    lvl(34'h0);
    xfer(rq(8'h06, 10'h3c6, 16'h1394), 8'h04);
    chk("excCrc", 16'ha343, respCrc);
    xfer(rq(8'h06, 10'h3e6, 16'h1394), 8'h00);
    chk("storeValid", 16'h0001, {15'h0, storeValid});
    chk("storeData", 16'h0032, storeData);
    chk("storeAddr", 16'h0114, storeAddr);
    xfer(rq(8'h41, 10'h3e6, 16'h1394), 8'h01);
  endtask
  // reads scale up, even of a read-only parameter; other known codes echo
  task automatic t_read;
    lvl({2'h0, 16'h0000, 16'h0005});
    xfer(rq(8'h03, 10'h3e9, 16'h0000), 8'h00);
    chk("data", 16'h0032, resp.data);
    xfer(rq(8'h08, 10'h3e0, 16'h0000), 8'h00);
    xfer(rq(8'h10, 10'h3e0, 16'h0000), 8'h00);
  endtask
  // locked until the stored password is written back
  task automatic t_pwd;
    lvl({2'h0, 16'h04d2, 16'h0005});
    xfer(rq(8'h03, 10'h3e0, 16'h0000), 8'h09);
    xfer(rq(8'h06, 10'h3f0, 16'h04d3), 8'h05);
    xfer(rq(8'h06, 10'h3f0, 16'h04d3), 8'h05);
    xfer(rq(8'h06, 10'h3f0, 16'h04d2), 8'h00);
    chk("unlocked", 16'h0001, {15'h0, unlocked});
    xfer(rq(8'h03, 10'h3e0, 16'h0000), 8'h00);
  endtask
  // reset in mid-run drops the unlock, so the password still guards
  task automatic t_rst;
    @(posedge clock);
    sys_rst <= 1'b1;
    #1;
    chk("rstUnlocked", 16'h0000, {15'h0, unlocked});
    chk("rstValid", 16'h0000, {15'h0, respValid});
    chk("rstCrc", 16'hffff, respCrc);
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    xfer(rq(8'h03, 10'h3e0, 16'h0000), 8'h09);
  endtask
  task automatic complete_run;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // reset for 4 cycles, then the scenarios
  initial
  begin
    sys_rst = 1'b1;
    {slaveFaulty, driveRunning, userPasswordSetting, storedValue} = 34'h0;
    repeat (4) @(posedge clock);
    chk("respCrc", 16'hffff, respCrc);
    sys_rst <= 1'b0;
    t_prio();
    t_read();
    t_pwd();
    t_rst();
    complete_run();
  end
  // watchdog, far beyond the roughly 50 cycles needed
  initial
  begin
    #2000;
    num_errors++;
    complete_run();
  end
endmodule
